// File: design/hfil_top.sv
// frame buffer and event logic: transmit and receive pools behind an Avalon-MM slave
// How it works
// - each write inside the transmit window with byte enable 0 set, unless the pool is full, goes to the slot of an internal pointer that then steps by one.
// - receive message end rises for a short frame or the last part of a long one, data readable.
// - receive pool full rises when one block of a still incomplete long frame is stored.
// - a frame that finds the receive pool occupied is dropped from that byte to its end and overflow rises.
// - after a transmit command, pool ready rises once a full block of space is free mid frame.
// - with transparent and end commands together, pool ready rises only after the frame is sent.
// - a collision after the 16th or 32nd data byte raises transmit message repeat.
// - an empty pool inside an unfinished frame aborts it with seven ones and raises underrun.
// - after message end the received byte count stands in the low and high byte count registers.
// - the host sets message end after the last block; unless extended transparent mode is on, the frame then gets checksum and flag.
// - the host sets message complete after reading a block; the device then frees that space.
// - a masked status bit reads zero, stays pending and shows once unmasked.
// - the transmit block size bit picks 32 bytes at zero and 16 bytes at one.
//
// The implementer's own choice: register access over Avalon-MM.
module hfil_top
  import hfil_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire logic [hfil_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [hfil_pkg::DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic [hfil_pkg::DATA_W-1:0] avs_readdata_o,
  output logic                        avs_waitrequest_o,
  output logic                        irq_o,
  output logic [7:0]                  ser_tx_byte_o,
  output logic                        ser_tx_valid_o,
  output logic                        ser_tx_abort_o,
  output logic                        ser_tx_close_o,
  input  wire logic                   ser_tx_ready_i,
  input  wire logic                   ser_collision_i,
  input  wire logic [7:0]             ser_rx_byte_i,
  input  wire logic                   ser_rx_valid_i,
  input  wire logic                   ser_rx_end_i
);
  import hfil_pkg::*;

  function automatic logic [CNT_W-1:0] rx_blk(input logic [1:0] sel);
    case (sel)
      2'b00:   rx_blk = BLK_32;
      2'b01:   rx_blk = BLK_16;
      2'b10:   rx_blk = BLK_8;
      default: rx_blk = BLK_4;
    endcase
  endfunction : rx_blk

  ////////////////////////////////////////////////////////////////////////
  // bus decode: one cycle of wait, answer on the second edge
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        req;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit_win;
  logic        hit_cmd;
  logic        hit_exm;
  logic        hit_mask;
  logic        hit_stat;
  logic        hit_rxd;
  assign req      = (avs_read_i || avs_write_i) && !ack_q;
  assign avs_waitrequest_o = req;
  assign wr_acc   = avs_write_i && ack_q && avs_byteenable_i[0];
  assign rd_acc   = avs_read_i && !ack_q;
  assign hit_win  = (avs_address_i >= TXWIN_LO) && (avs_address_i <= TXWIN_HI);
  assign hit_cmd  = avs_address_i == REG_CMD;
  assign hit_exm  = avs_address_i == REG_EXMODE;
  assign hit_mask = avs_address_i == REG_MASK;
  assign hit_stat = avs_address_i == REG_STATUS;
  assign hit_rxd  = avs_address_i == REG_RXDATA;

  logic [7:0] wb;
  assign wb = avs_writedata_i[7:0];

  ////////////////////////////////////////////////////////////////////////
  // configuration and commands
  logic [7:0] exm_q;
  logic       cmd_xtf;
  logic       cmd_xme;
  logic       cmd_xres;
  logic       cmd_rmc;
  logic       cmd_rres;
  logic       tx_cmd;
  assign cmd_xtf  = wr_acc && hit_cmd && wb[CMD_XTF];
  assign cmd_xme  = wr_acc && hit_cmd && wb[CMD_XME];
  assign cmd_xres = wr_acc && hit_cmd && wb[CMD_XRES];
  assign cmd_rmc  = wr_acc && hit_cmd && wb[CMD_RMC];
  assign cmd_rres = wr_acc && hit_cmd && wb[CMD_RRES];
  assign tx_cmd   = cmd_xtf || cmd_xme || cmd_xres;

  // block sizes latch on the matching command
  logic [CNT_W-1:0] txblk_q;
  logic [CNT_W-1:0] rxblk_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      exm_q   <= 8'h00;
      txblk_q <= BLK_32;
      rxblk_q <= BLK_32;
    end else begin
      if (wr_acc && hit_exm) begin
        exm_q <= wb;
      end
      if (tx_cmd) begin
        txblk_q <= exm_q[EXM_TX_BLOCK_SIZE_SEL] ? BLK_16 : BLK_32;
      end
      if (cmd_rmc || cmd_rres) begin
        rxblk_q <= rx_blk(exm_q[EXM_RX_BLOCK_SIZE_SEL_HI:EXM_RX_BLOCK_SIZE_SEL_LO]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit pool: write pointer, read pointer, fill count
  logic [7:0]       txmem_q [TX_DEPTH];
  logic [PTR_W-1:0] txw_q;
  logic [PTR_W-1:0] txr_q;
  logic [CNT_W-1:0] txcnt_q;
  logic [CNT_W-1:0] txsent_q;
  logic             tx_push;
  logic             tx_pop;
  logic             tx_end_q;
  logic             tx_last_q;
  logic             tx_go_q;
  logic             xpr_wait_q;
  logic [3:0]       ones_q;
  hfil_tx_state_t   txst_q;
  assign tx_push = wr_acc && hit_win && (txcnt_q < TX_DEPTH[CNT_W-1:0]);
  assign tx_pop  = (txst_q == HFIL_TX_SEND) && tx_go_q && (txcnt_q != '0) && ser_tx_ready_i;

  // window writes land in the pointed slot, then step
  always_ff @(posedge mclk_i) begin
    if (tx_push) begin
      txmem_q[txw_q] <= wb;
    end
  end

  logic tx_free_blk;
  logic tx_underrun;
  logic tx_done;
  logic xmr_ev;
  logic tx_xpr;
  assign tx_free_blk = (TX_DEPTH[CNT_W-1:0] - txcnt_q) >= txblk_q;
  assign tx_underrun = (txst_q == HFIL_TX_SEND) && tx_go_q && (txcnt_q == '0) && !tx_end_q;
  assign tx_done     = (txst_q == HFIL_TX_CLOSE) && ser_tx_ready_i;
  assign xmr_ev      = (txst_q == HFIL_TX_SEND) && ser_collision_i && (txsent_q >= txblk_q);
  // mid frame a free block signals ready; xtf with xme waits for the end
  assign tx_xpr = (xpr_wait_q && !tx_last_q && tx_free_blk) || tx_done;

  always_ff @(posedge mclk_i) begin
    if (rst_i || cmd_xres) begin
      txw_q      <= '0;
      txr_q      <= '0;
      txcnt_q    <= '0;
      txsent_q   <= '0;
      tx_end_q   <= 1'b0;
      tx_last_q  <= 1'b0;
      tx_go_q    <= 1'b0;
      xpr_wait_q <= 1'b0;
      ones_q     <= '0;
      txst_q     <= HFIL_TX_IDLE;
    end else begin
      if (tx_push) begin
        txw_q <= txw_q + 1'b1;
      end
      if (tx_pop) begin
        txr_q    <= txr_q + 1'b1;
        txsent_q <= (txsent_q == 7'd127) ? txsent_q : txsent_q + 1'b1;
      end
      txcnt_q <= txcnt_q + {6'd0, tx_push} - {6'd0, tx_pop};
      if (cmd_xtf || cmd_xme) begin
        tx_go_q    <= 1'b1;
        xpr_wait_q <= 1'b1;
        tx_end_q   <= tx_end_q || cmd_xme;
        tx_last_q  <= cmd_xtf && cmd_xme;
      end else if (tx_xpr) begin
        xpr_wait_q <= 1'b0;
      end
      unique case (txst_q)
        HFIL_TX_IDLE: begin
          if (cmd_xtf) begin
            txst_q   <= HFIL_TX_SEND;
            txsent_q <= '0;
          end
        end
        HFIL_TX_SEND: begin
          if (tx_underrun) begin
            txst_q <= HFIL_TX_ABORT;
            ones_q <= '0;
          end else if (tx_end_q && txcnt_q == '0) begin
            txst_q <= HFIL_TX_CLOSE;
          end else if (xmr_ev) begin
            txst_q <= HFIL_TX_IDLE;
          end
        end
        HFIL_TX_CLOSE: begin
          if (ser_tx_ready_i) begin
            txst_q   <= HFIL_TX_IDLE;
            tx_end_q <= 1'b0;
            tx_go_q  <= 1'b0;
          end
        end
        HFIL_TX_ABORT: begin
          if (ser_tx_ready_i) begin
            ones_q <= ones_q + 1'b1;
            if (ones_q == ABORT_ONES - 4'd1) begin
              txst_q  <= HFIL_TX_IDLE;
              tx_go_q <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // serial side outputs from flip-flops
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ser_tx_byte_o  <= 8'h00;
      ser_tx_valid_o <= 1'b0;
      ser_tx_abort_o <= 1'b0;
      ser_tx_close_o <= 1'b0;
    end else begin
      ser_tx_valid_o <= tx_pop;
      if (tx_pop) begin
        ser_tx_byte_o <= txmem_q[txr_q];
      end
      ser_tx_abort_o <= (txst_q == HFIL_TX_ABORT) && ser_tx_ready_i;
      ser_tx_close_o <= tx_done && !exm_q[EXM_EXT_TRANSP];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive pool: one frame's blocks, freed by message complete
  logic [7:0]       rxmem_q [RX_DEPTH];
  logic [PTR_W-1:0] rxw_q;
  logic [PTR_W-1:0] rxr_q;
  logic [CNT_W-1:0] rxcnt_q;
  logic [CNT_W-1:0] blkcnt_q;
  logic [15:0]      frame_len_q;
  logic [15:0]      rbc_q;
  logic             held_q;
  logic             drop_q;
  logic             rx_store;
  logic             blk_full;
  logic             rme_ev;
  logic             rpf_ev;
  logic             rfo_ev;
  logic             rx_pop;
  assign rx_store = ser_rx_valid_i && !drop_q && !held_q;
  assign blk_full = rx_store && (blkcnt_q + 1'b1 == rxblk_q) && !ser_rx_end_i;
  assign rpf_ev   = blk_full;
  assign rme_ev   = ser_rx_end_i && !drop_q && !(held_q && ser_rx_valid_i);
  assign rfo_ev   = ser_rx_valid_i && held_q && !drop_q;
  assign rx_pop   = avs_read_i && ack_q && hit_rxd && (rxcnt_q != '0);

  always_ff @(posedge mclk_i) begin
    if (rx_store) begin
      rxmem_q[rxw_q] <= ser_rx_byte_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || cmd_rres) begin
      rxw_q       <= '0;
      rxr_q       <= '0;
      rxcnt_q     <= '0;
      blkcnt_q    <= '0;
      frame_len_q <= '0;
      rbc_q       <= '0;
      held_q      <= 1'b0;
      drop_q      <= 1'b0;
    end else begin
      if (rx_store) begin
        rxw_q       <= rxw_q + 1'b1;
        blkcnt_q    <= blk_full ? '0 : blkcnt_q + 1'b1;
        frame_len_q <= frame_len_q + 16'd1;
      end
      if (rx_pop) begin
        rxr_q <= rxr_q + 1'b1;
      end
      // the held block stays until the host confirms it
      if (cmd_rmc) begin
        rxcnt_q <= '0;
        rxr_q   <= rxw_q;
        held_q  <= 1'b0;
      end else begin
        rxcnt_q <= rxcnt_q + {6'd0, rx_store} - {6'd0, rx_pop};
        if (blk_full || rme_ev) begin
          held_q <= 1'b1;
        end
      end
      if (rfo_ev) begin
        drop_q <= 1'b1;
      end
      if (ser_rx_end_i) begin
        drop_q      <= 1'b0;
        frame_len_q <= '0;
        blkcnt_q    <= '0;
        if (rme_ev) begin
          rbc_q <= frame_len_q + {15'd0, rx_store};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events, mask and interrupt
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  logic [7:0] stat_view;
  logic [7:0] mask_view;
  always_comb begin
    ev_set         = 8'h00;
    ev_set[EV_RME] = rme_ev;
    ev_set[EV_RPF] = rpf_ev;
    ev_set[EV_RFO] = rfo_ev;
    ev_set[EV_XPR] = tx_xpr;
    ev_set[EV_XMR] = xmr_ev;
    ev_set[EV_XDU] = tx_underrun;
  end
  assign ev_clr = (wr_acc && hit_stat) ? wb : 8'h00;

  hfil_event_regs u_events (
    .mclk_i        (mclk_i),
    .rst_i         (rst_i),
    .set_i         (ev_set),
    .clear_i       (ev_clr),
    .mask_we_i     (wr_acc && hit_mask),
    .mask_wdata_i  (wb),
    .status_view_o (stat_view),
    .mask_o        (mask_view),
    .irq_o         (irq_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux and answer
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (avs_address_i)
      REG_STATUS:   rmux[7:0] = stat_view;
      REG_MASK:     rmux[7:0] = mask_view;
      REG_EXMODE:   rmux[7:0] = exm_q;
      REG_RXDATA:   rmux[7:0] = rxmem_q[rxr_q];
      REG_RBC_LOW:  rmux[7:0] = rbc_q[7:0];
      REG_RBC_HIGH: rmux[7:0] = rbc_q[15:8];
      REG_STATE:    rmux[7:0] = {(txst_q != HFIL_TX_IDLE), held_q, 4'h0, txst_q};
      default:      rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (rd_acc) begin
        rdata_q <= rmux;
      end
    end
  end
  assign avs_readdata_o = rdata_q;

  AST_PTR_STEP: assert property (@(posedge mclk_i) disable iff (rst_i || cmd_xres)
    tx_push |=> txw_q == $past(txw_q) + 1'b1)
    else $error("transmit pointer did not step");
  AST_UNDERRUN_ABORT: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tx_underrun && !cmd_xres) |=> txst_q == HFIL_TX_ABORT)
    else $error("underrun without abort");
  AST_RFO_DROP: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rfo_ev && !ser_rx_end_i && !cmd_rres) |=> drop_q)
    else $error("overflow frame not dropped");
  AST_RPF_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rpf_ev && !cmd_rmc && !cmd_rres) |=> held_q && !rx_store)
    else $error("pool full did not hold the block");
  AST_BLK_SIZE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tx_cmd && exm_q[EXM_TX_BLOCK_SIZE_SEL]) |=> txblk_q == BLK_16)
    else $error("block size select ignored");
  AST_XPR_LAST: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tx_xpr && tx_last_q) |-> tx_done)
    else $error("ready before frame end");
  AST_RBC: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rme_ev && !cmd_rres) |=> rbc_q == $past(frame_len_q) + {15'd0, $past(rx_store)})
    else $error("byte count wrong");
  AST_RMC_FREE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cmd_rmc && !cmd_rres) |=> !held_q && rxcnt_q == '0)
    else $error("message complete did not free");
  AST_WAIT_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
    req |=> !avs_waitrequest_o)
    else $error("waitrequest longer than one cycle");
endmodule : hfil_top

// File: design/hfil_pkg.sv
// package: register map, field layout and sizes of the frame buffer and event logic
package hfil_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          TX_DEPTH        = 64;
  localparam int          RX_DEPTH        = 64;
  localparam int          PTR_W           = 6;
  localparam int          CNT_W           = 7;
  // register byte addresses (word index times four)
  localparam logic [7:0]  TXWIN_LO        = 8'h00;
  localparam logic [7:0]  TXWIN_HI        = 8'h1F;
  localparam logic [7:0]  REG_STATUS      = 8'h80;
  localparam logic [7:0]  REG_MASK        = 8'h84;
  localparam logic [7:0]  REG_CMD         = 8'h88;
  localparam logic [7:0]  REG_EXMODE      = 8'h8C;
  localparam logic [7:0]  REG_RXDATA      = 8'h90;
  localparam logic [7:0]  REG_RBC_LOW     = 8'h94;
  localparam logic [7:0]  REG_RBC_HIGH    = 8'h98;
  localparam logic [7:0]  REG_STATE       = 8'h9C;
  // event bit positions
  localparam int          EV_RME          = 7;
  localparam int          EV_RPF          = 6;
  localparam int          EV_RFO          = 5;
  localparam int          EV_XPR          = 4;
  localparam int          EV_XMR          = 3;
  localparam int          EV_XDU          = 2;
  localparam logic [7:0]  EV_USED         = 8'hFC;
  localparam logic [7:0]  STATUS_RESET    = 8'h10;
  localparam logic [7:0]  MASK_RESET      = 8'hFC;
  // command bits
  localparam int          CMD_RMC         = 7;
  localparam int          CMD_RRES        = 6;
  localparam int          CMD_XTF         = 3;
  localparam int          CMD_XME         = 1;
  localparam int          CMD_XRES        = 0;
  // extended mode bits
  localparam int          EXM_TX_BLOCK_SIZE_SEL        = 7;
  localparam int          EXM_RX_BLOCK_SIZE_SEL_HI     = 6;
  localparam int          EXM_RX_BLOCK_SIZE_SEL_LO     = 5;
  localparam int          EXM_EXT_TRANSP  = 0;
  localparam logic [CNT_W-1:0] BLK_32     = 7'd32;
  localparam logic [CNT_W-1:0] BLK_16     = 7'd16;
  localparam logic [CNT_W-1:0] BLK_8      = 7'd8;
  localparam logic [CNT_W-1:0] BLK_4      = 7'd4;
  localparam logic [3:0]  ABORT_ONES      = 4'd7;
  typedef enum logic [1:0] {
    HFIL_TX_IDLE  = 2'b00,
    HFIL_TX_SEND  = 2'b01,
    HFIL_TX_CLOSE = 2'b10,
    HFIL_TX_ABORT = 2'b11
  } hfil_tx_state_t;
endpackage : hfil_pkg

// File: design/hfil_event_regs.sv
// sticky event status with write-one-to-clear, mask and interrupt output
module hfil_event_regs
  import hfil_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] set_i,
  input  wire logic [7:0] clear_i,
  input  wire logic       mask_we_i,
  input  wire logic [7:0] mask_wdata_i,
  output logic [7:0]      status_view_o,
  output logic [7:0]      mask_o,
  output logic            irq_o
);
  logic [7:0] pend_q;
  logic [7:0] pend_d;
  logic [7:0] mask_q;

  // set wins over clear in the same cycle
  assign pend_d = ((pend_q & ~clear_i) | set_i) & EV_USED;

  ////////////////////////////////////////////////////////////////////////
  // pending and mask storage
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend_q <= STATUS_RESET;
      mask_q <= MASK_RESET;
    end else begin
      pend_q <= pend_d;
      if (mask_we_i) begin
        mask_q <= mask_wdata_i & EV_USED;
      end
    end
  end

  // masked bits read as zero yet stay pending
  assign status_view_o = pend_q & ~mask_q;
  assign mask_o        = mask_q;
  assign irq_o         = |(pend_q & ~mask_q);

  AST_MASK_HIDES: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pend_q[EV_RME] && mask_q[EV_RME]) |-> !status_view_o[EV_RME])
    else $error("masked event is visible");
  AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((pend_q & ~mask_q) != 8'h00) |-> irq_o)
    else $error("irq low with unmasked event");
  AST_SET_WINS: assert property (@(posedge mclk_i) disable iff (rst_i)
    (set_i[EV_XPR] && clear_i[EV_XPR]) |=> pend_q[EV_XPR])
    else $error("event lost during clear");
endmodule : hfil_event_regs

// File: testbench/hfil_ser_model.sv
// serial channel model: takes transmit bytes with stalls and sends receive frames
module hfil_ser_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_abort_i,
  input  wire logic       tx_close_i,
  output logic            tx_ready_o,
  output logic            collision_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  output logic            rx_end_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txq[$];
  int         aborts = 0;
  int         closes = 0;
  logic [2:0] tick_q = 3'h0;
  logic       busy = 1'b0;
  logic       hold = 1'b0;
  initial begin
    tx_ready_o  = 1'b0;
    collision_o = 1'b0;
    rx_byte_o   = 8'h00;
    rx_valid_o  = 1'b0;
    rx_end_o    = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // ready drops one cycle in eight so the sender sees a slow line; log what leaves
  always @(posedge mclk_i) begin
    tick_q     <= tick_q + 3'h1;
    tx_ready_o <= !rst_i && !hold && (tick_q != 3'h3);
    if (!rst_i && tx_valid_i) txq.push_back(tx_byte_i);
    if (!rst_i && tx_abort_i) aborts++;
    if (!rst_i && tx_close_i) closes++;
    if (!busy) rx_byte_o <= ~rx_byte_o; // idle data line never holds the last byte
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one frame of n bytes counting up from base, end marked with the last byte
  task automatic send_frame(input int n, input logic [7:0] base);
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_i);
      rx_byte_o  <= base + 8'(i);
      rx_valid_o <= 1'b1;
      rx_end_o   <= (i == n - 1);
    end
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    rx_end_o   <= 1'b0;
    busy = 1'b0;
  endtask : send_frame
  // hold the line off, or raise one collision pulse for a single cycle
  task automatic set_hold(input logic h);
    hold <= h;
  endtask : set_hold
  task automatic collide;
    @(posedge mclk_i);
    collision_o <= 1'b1;
    @(posedge mclk_i);
    collision_o <= 1'b0;
  endtask : collide
endmodule : hfil_ser_model

// File: testbench/hfil_top_tb.sv
// testbench: register, interrupt, transmit and receive scenarios of the frame logic
module hfil_top_tb import hfil_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic              rd_en = 1'b0;
  logic              wr_en = 1'b0;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic [DATA_W-1:0] rdata;
  logic              waitreq, irq, txv, txa, txc, txr, coll, rxv, rxe;
  logic [7:0]        txb, rxb;
  logic [31:0]       q;
  int                errors = 0;
  int                samples_checked = 0;
  hfil_top hfil_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .irq_o(irq), .ser_tx_byte_o(txb), .ser_tx_valid_o(txv), .ser_tx_abort_o(txa),
    .ser_tx_close_o(txc), .ser_tx_ready_i(txr), .ser_collision_i(coll),
    .ser_rx_byte_i(rxb), .ser_rx_valid_i(rxv), .ser_rx_end_i(rxe));
  hfil_ser_model hfil_ser_model_i (.mclk_i(mclk_i), .rst_i(rst_i), .tx_byte_i(txb),
    .tx_valid_i(txv), .tx_abort_i(txa), .tx_close_i(txc), .tx_ready_o(txr),
    .collision_o(coll), .rx_byte_o(rxb), .rx_valid_o(rxv), .rx_end_o(rxe));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, verdict and comparison
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  ////////////////////////////////////////////////////////////////////////////////
  // one bus access held until waitrequest is seen low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr  <= a;
    wdata <= {24'h000000, d};
    wr_en <= w;
    rd_en <= !w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (n >= 50) begin
      errors++;
      finish_test();
    end
    @(posedge mclk_i); // idle edge: the next access never reassigns in this step
  endtask : bus
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STATUS, 8'h00);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    if (n >= 300) begin
      errors++;
      finish_test();
    end
  endtask : wait_bit
  ////////////////////////////////////////////////////////////////////////////////
  // reset values, masking, interrupt level, clearing and an unmapped read
  task automatic t_regs;
    bus(1'b0, REG_STATUS, 8'h00);
    check(q, 32'h0);
    bus(1'b0, REG_MASK, 8'h00);
    check(q, {24'h0, MASK_RESET});
    check({31'h0, irq}, 32'h0);
    bus(1'b1, REG_MASK, 8'hEC);
    bus(1'b0, REG_STATUS, 8'h00);
    check(q, {24'h0, STATUS_RESET});
    check({31'h0, irq}, 32'h1);
    bus(1'b1, REG_STATUS, 8'h10);
    bus(1'b0, REG_STATUS, 8'h00);
    check(q, 32'h0);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, 8'hA0, 8'h00);
    check(q, 32'h0);
    bus(1'b1, REG_MASK, 8'h00);
    $display("test regs done");
  endtask : t_regs
  // one 16 byte block sent as a whole frame, scattered window addresses
  task automatic t_tx_frame;
    bus(1'b1, REG_EXMODE, 8'h80);
    for (int i = 0; i < 16; i++) bus(1'b1, 8'((i * 5) % 32), 8'hA0 + 8'(i));
    bus(1'b1, REG_CMD, 8'h0A);
    wait_bit(EV_XPR);
    check(hfil_ser_model_i.txq.size(), 32'd16);
    for (int i = 0; i < 16; i++) check(hfil_ser_model_i.txq[i], 32'hA0 + i);
    check(hfil_ser_model_i.closes, 32'd1);
    check(hfil_ser_model_i.aborts, 32'd0);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, REG_STATUS, 8'hFC);
    $display("test tx frame done");
  endtask : t_tx_frame
  // an unfinished frame runs dry and is aborted
  task automatic t_underrun;
    hfil_ser_model_i.txq.delete();
    for (int i = 0; i < 4; i++) bus(1'b1, 8'h00, 8'h40 + 8'(i));
    bus(1'b1, REG_CMD, 8'h08);
    wait_bit(EV_XDU);
    repeat (40) @(posedge mclk_i); // lets the abort ones drain out
    check(hfil_ser_model_i.aborts, 32'd7);
    check(hfil_ser_model_i.txq.size(), 32'd4);
    bus(1'b1, REG_STATUS, 8'hFC);
    $display("test underrun done");
  endtask : t_underrun
  // two blocks loaded mid frame; a collision inside the first block is ignored, later repeats
  task automatic t_collision;
    int n;
    hfil_ser_model_i.txq.delete();
    hfil_ser_model_i.set_hold(1'b1);
    bus(1'b1, REG_EXMODE, 8'h80);
    for (int i = 0; i < 16; i++) bus(1'b1, 8'h00, 8'h60 + 8'(i));
    bus(1'b1, REG_CMD, 8'h08);
    wait_bit(EV_XPR);
    for (int i = 16; i < 32; i++) bus(1'b1, 8'h00, 8'h60 + 8'(i));
    bus(1'b1, REG_CMD, 8'h08);
    hfil_ser_model_i.set_hold(1'b0);
    for (int lim = 2; lim <= 18; lim += 16) begin
      n = 0;
      while (hfil_ser_model_i.txq.size() < lim && n < 100) begin
        @(posedge mclk_i);
        n++;
      end
      if (n >= 100) begin
        errors++;
        finish_test();
      end
      hfil_ser_model_i.collide();
      bus(1'b0, REG_STATUS, 8'h00);
      check(q & 32'h0C, (lim > 16) ? 32'h08 : 32'h00);
    end
    bus(1'b1, REG_CMD, 8'h01);
    bus(1'b1, REG_STATUS, 8'hFC);
    $display("test collision done");
  endtask : t_collision
  // short frame, then a long frame that fills a block and overruns the held pool
  task automatic t_rx;
    bus(1'b1, REG_EXMODE, 8'h20);
    bus(1'b1, REG_CMD, 8'h40);
    hfil_ser_model_i.send_frame(5, 8'h30);
    wait_bit(EV_RME);
    bus(1'b0, REG_RBC_LOW, 8'h00);
    check(q, 32'd5);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, REG_RXDATA, 8'h00);
      check(q, 32'h30 + i);
    end
    bus(1'b1, REG_CMD, 8'h80);
    bus(1'b1, REG_STATUS, 8'hFC);
    hfil_ser_model_i.send_frame(20, 8'h50);
    bus(1'b0, REG_STATUS, 8'h00);
    check(q & 32'hC0, 32'h40);
    wait_bit(EV_RFO);
    bus(1'b0, REG_RXDATA, 8'h00);
    check(q, 32'h50);
    $display("test rx done");
  endtask : t_rx
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    t_regs();
    t_tx_frame();
    t_underrun();
    t_collision();
    t_rx();
    finish_test();
  end
endmodule : hfil_top_tb
